// file: mscp_port.sv
// Serial control port: shift register, address/data latch, channel settings.
// Assumes serial pins already synchronous to clk; no own sync stage.
// Each serial level must stand at least one clk cycle, or an edge is lost.
`timescale 1ns/100ps
module mscp_port
  import mscp_pkg::*;
#(
  parameter int NUM_INPUTS = MSCP_NUM_INPUTS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic four_wire_mode,
  input wire mscp_serial_type serial_in,
  output logic data_out,
  output mscp_chan_type [NUM_INPUTS-1:0] chan_settings,
  output logic [2:0] selected_input
);
  // ==========================================================
  // Parameter check
  // The input select field is three bits, so more than eight inputs cannot be reached
  generate
    if (NUM_INPUTS < 1 || NUM_INPUTS > MSCP_NUM_INPUTS) begin : g_bad_inputs
      $error("NUM_INPUTS must lie between 1 and 8");
    end
  endgenerate

  // ==========================================================
  // Reset value of one input's settings
  // Inputs start switched off both outputs and at no loss
  localparam mscp_chan_type CHAN_RESET = '{
    left_on: MSCP_ROUTE_RESET,
    right_on: MSCP_ROUTE_RESET,
    atten: MSCP_ATTEN_RESET
  };

  // ==========================================================
  // Byte decoding
  // A data level above 7fh would set the flag and be misread as an address
  function automatic logic byte_is_addr(
    input logic [MSCP_BYTE_BITS-1:0] b
  );
    byte_is_addr = b[MSCP_ADDR_FLAG_POS];
  endfunction

  function automatic logic [2:0] byte_input(
    input logic [MSCP_BYTE_BITS-1:0] b
  );
    byte_input = b[MSCP_SEL_MSB:0];
  endfunction

  // The cast keeps the compare at the width of the select field
  function automatic logic input_match(
    input logic [2:0] sel,
    input int idx
  );
    input_match = (sel == 3'(idx));
  endfunction

  function automatic mscp_chan_type with_route(
    input mscp_chan_type chan,
    input logic [MSCP_BYTE_BITS-1:0] b
  );
    mscp_chan_type result;
    result = chan;
    result.left_on = b[MSCP_LEFT_POS];
    result.right_on = b[MSCP_RIGHT_POS];
    with_route = result;
  endfunction

  // Only the low six bits are taken; the flag bit has already marked the byte as data
  function automatic mscp_chan_type with_atten(
    input mscp_chan_type chan,
    input logic [MSCP_BYTE_BITS-1:0] b
  );
    mscp_chan_type result;
    result = chan;
    result.atten = b[MSCP_ATTEN_MSB:0];
    with_atten = result;
  endfunction

  // ==========================================================
  // Serial pins
  wire sclk_pin = serial_in.sclk;
  wire sdata_pin = serial_in.sdata;
  wire shift_en_n_pin = serial_in.shift_en_n;
  wire latch_pin = serial_in.latch;

  // ==========================================================
  // Edge detectors
  // Reset high, so a pin that idles high at release raises no false edge
  logic sclk_q;
  logic select_q;
  logic latch_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclk_q <= MSCP_EDGE_RESET;
    end else begin
      sclk_q <= sclk_pin;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      select_q <= MSCP_EDGE_RESET;
    end else begin
      select_q <= shift_en_n_pin;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      latch_q <= MSCP_EDGE_RESET;
    end else begin
      latch_q <= latch_pin;
    end
  end

  // Rising edges of the three serial controls
  wire sclk_rise = sclk_pin & ~sclk_q;
  wire select_rise = shift_en_n_pin & ~select_q;
  wire latch_rise = latch_pin & ~latch_q;

  // ==========================================================
  // Shift register; never cleared between bytes
  logic [MSCP_BYTE_BITS-1:0] shift;
  // Sampling only while select low keeps stray clocks between bytes harmless
  wire shift_now = sclk_rise & ~shift_en_n_pin;
  wire [MSCP_BYTE_BITS-1:0] shifted = {shift[MSCP_BYTE_BITS-2:0], sdata_pin};
  // A short byte leaves old low bits at the top, which may then read as an address
  wire [MSCP_BYTE_BITS-1:0] next_shift = shift_now ? shifted : shift;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shift <= MSCP_SHIFT_RESET;
    end else begin
      shift <= next_shift;
    end
  end

  // ==========================================================
  // Chain output
  // Top bit leaves first into the next device's data input; one clk of delay
  // still lands before that device samples the next serial clock edge
  wire next_data_out = shift[MSCP_BYTE_BITS-1];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      data_out <= MSCP_CHAIN_RESET;
    end else begin
      data_out <= next_data_out;
    end
  end

  // ==========================================================
  // Latch strobe and byte type
  // Three-wire: select rise latches; four-wire: separate strobe does
  wire latch_now = four_wire_mode ? latch_rise : select_rise;

  // Decoding looks at the byte as it stands at the strobe
  wire is_addr = byte_is_addr(shift);
  wire [2:0] addr_sel = byte_input(shift);
  wire addr_latch = latch_now & is_addr;
  wire data_latch = latch_now & ~is_addr;

  // ==========================================================
  // Address latch
  // A data byte with no address before it goes to input 0
  // Data bytes leave the selection alone, so a level can be sent again
  wire [2:0] next_selected_input = addr_latch ? addr_sel : selected_input;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      selected_input <= MSCP_SEL_RESET;
    end else begin
      selected_input <= next_selected_input;
    end
  end

  // ==========================================================
  // Per-input settings
  wire mscp_chan_type [NUM_INPUTS-1:0] next_chan_settings;

  genvar i;
  generate
    for (i = 0; i < NUM_INPUTS; i++) begin : g_chan
      wire addr_hit = addr_latch & input_match(addr_sel, i);
      wire data_hit = data_latch & input_match(selected_input, i);
      wire mscp_chan_type routed = with_route(chan_settings[i], shift);
      wire mscp_chan_type attenuated = with_atten(chan_settings[i], shift);
      wire mscp_chan_type kept = chan_settings[i];
      // Routing and level are written apart, so an address byte keeps the level
      wire mscp_chan_type after_data = data_hit ? attenuated : kept;

      assign next_chan_settings[i] = addr_hit ? routed : after_data;
    end
  endgenerate

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      chan_settings <= {NUM_INPUTS{CHAN_RESET}};
    end else begin
      chan_settings <= next_chan_settings;
    end
  end
endmodule

// file: mscp_pkg.sv
// Constants and carrier types for the mixer serial control port.
// Assumes a single 100 MHz system clock; serial pins are synchronous inputs.
package mscp_pkg;
  // ==========================================================
  // Byte layout
  localparam int MSCP_BYTE_BITS = 8;
  localparam int MSCP_ADDR_FLAG_POS = 7;
  localparam int MSCP_LEFT_POS = 4;
  localparam int MSCP_RIGHT_POS = 3;
  localparam int MSCP_SEL_MSB = 2;
  localparam int MSCP_ATTEN_MSB = 5;
  localparam int MSCP_NUM_INPUTS = 8;
  // ==========================================================
  // Reset values
  localparam logic [7:0] MSCP_SHIFT_RESET = 8'h00;
  localparam logic [5:0] MSCP_ATTEN_RESET = 6'h00;
  localparam logic [2:0] MSCP_SEL_RESET = 3'h0;
  localparam logic MSCP_EDGE_RESET = 1'b1;
  localparam logic MSCP_ROUTE_RESET = 1'b0;
  localparam logic MSCP_CHAIN_RESET = 1'b0;

  typedef struct packed {
    logic sclk;
    logic sdata;
    logic shift_en_n;
    logic latch;
  } mscp_serial_type;

  typedef struct packed {
    logic left_on;
    logic right_on;
    logic [5:0] atten;
  } mscp_chan_type;
endpackage

// file: mscp_port_checker.sv
// Pin checker for the control port; pins assumed synchronous to clk.
`timescale 1ns/100ps
module mscp_port_checker import mscp_pkg::*; #(parameter int NUM_INPUTS = MSCP_NUM_INPUTS) (
  input wire logic clk,
  input wire logic reset,
  input wire logic four_wire_mode,
  input wire logic data_out,
  input wire mscp_serial_type serial_in,
  input wire mscp_chan_type [NUM_INPUTS-1:0] chan_settings,
  input wire logic [2:0] selected_input);
  logic ckq, ltq, rq;
  logic [7:0] sh;
  wire lt = four_wire_mode ? serial_in.latch : serial_in.shift_en_n;
  wire bt = serial_in.sclk & !ckq & !serial_in.shift_en_n;
  wire rs = lt & !ltq;
  wire ad = rs & sh[7];
  wire dt = rs & !sh[7];
  wire [2:0] si = selected_input;
  // Edges reset high so idle pins make no event; update may land one or two edges late
  always_ff @(posedge clk or posedge reset)
    {ckq, ltq, rq, sh} <= reset ? 11'h600 :
      {serial_in.sclk, lt, rs, bt ? {sh[6:0], serial_in.sdata} : sh};
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  set_hold_a: assert property (!(rs||rq) |=> $stable(chan_settings)) else $error("set");
  sel_hold_a: assert property (!(rs||rq) |=> $stable(si)) else $error("sel");
  addr_sel_a: assert property (ad |-> ##[1:2] si == sh[2:0]) else $error("adr");
  addr_route_a: assert property (ad |-> ##[1:2] chan_settings[si][7:6] == sh[4:3])
    else $error("route");
  data_val_a: assert property (dt |-> ##[1:2] chan_settings[si].atten == sh[5:0])
    else $error("atten");
  data_sel_a: assert property (dt |=> $stable(si)[*2]) else $error("sel");
  chain_out_a: assert property (data_out == $past(sh[7])) else $error("out");
  chain_hold_a: assert property ($changed(data_out) |-> $past(bt, 2))
    else $error("out");
  cover property (ad);
  cover property (dt);
  cover property (rs && four_wire_mode);
endmodule
bind mscp_port mscp_port_checker #(.NUM_INPUTS(NUM_INPUTS)) chk_u (.*);

// file: mscp_host.sv
// Host model driving the serial pins; its task is called at falling edges.
`timescale 1ns/100ps
module mscp_host import mscp_pkg::*; (
  input wire logic clk,
  input wire logic four_wire_mode,
  output mscp_serial_type pins);
  initial pins = 4'ha;
  // Released data shows the inverse of the last bit, never a held value
  task automatic send(input logic [7:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      pins = {1'b0, v[i], 2'b00};
      repeat (2) @(negedge clk);
      pins.sclk = 1'b1;
      repeat (2) @(negedge clk);
    end
    pins = {1'b1, !pins.sdata, 2'b10};
    repeat (3) @(negedge clk);
    pins.latch = four_wire_mode;
    repeat (3) @(negedge clk);
    pins.latch = 1'b0;
    repeat (3) @(negedge clk);
  endtask
endmodule

// file: mscp_port_bench.sv
// Bench for the control port; the host model drives all serial pins.
`timescale 1ns/100ps
module mscp_port_bench import mscp_pkg::*; ;
  logic clk = 1'b0, reset = 1'b1, four_wire_mode = 1'b0, data_out;
  mscp_serial_type serial_in;
  mscp_chan_type [7:0] chan_settings;
  logic [2:0] selected_input;
  int num_errors = 0, checked = 0;
  always #5 clk = ~clk;
  mscp_host host_u (.clk, .four_wire_mode, .pins(serial_in));
  mscp_port dut_u (.clk, .reset, .four_wire_mode, .serial_in, .data_out, .chan_settings,
    .selected_input);
  task automatic check(input string s, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) num_errors++;
    if (seen !== exp) $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic three_wire_test();
    host_u.send(8'h9a, 8);
    check("chain", {7'h00, data_out}, 8'h01);
    host_u.send(8'h0b, 8);
    check("in2", chan_settings[2], 8'hcb);
    host_u.send(8'h01, 6);
    check("sel", {5'h00, selected_input}, 8'h01);
    $display("three_wire_test done");
  endtask
  task automatic route_test();
    host_u.send(8'h95, 8);
    host_u.send(8'h2a, 8);
    check("in5", chan_settings[5], 8'haa);
    host_u.send(8'h8b, 8);
    check("in3", chan_settings[3], 8'h40);
    check("sel3", {5'h00, selected_input}, 8'h03);
    check("in5 kept", chan_settings[5], 8'haa);
    $display("route_test done");
  endtask
  task automatic reset_test();
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    host_u.send(8'h05, 8);
    check("in0", chan_settings[0], 8'h05);
    check("sel0", {5'h00, selected_input}, 8'h00);
    $display("reset_test done");
  endtask
  task automatic four_test();
    four_wire_mode = 1'b1;
    host_u.send(8'h9e, 8);
    host_u.send(8'h31, 8);
    check("in6", chan_settings[6], 8'hf1);
    $display("four_test done");
  endtask
  initial begin
    repeat (16) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    three_wire_test();
    route_test();
    four_test();
    reset_test();
    summarize();
  end
  // Run takes about 4 us; a hang is cut off well after that
  initial begin
    #20us num_errors++;
    summarize();
  end
endmodule
